// ==== t2cs_regs.svh ====
// register addresses, field positions, reset values and count limits of the timer 2 block
`ifndef T2CS_REGS_SVH
`define T2CS_REGS_SVH

// ---------------------------------------------------------------
// special function addresses
// ---------------------------------------------------------------
`define T2CS_ADDR_CONTROL   8'hC8
`define T2CS_ADDR_RELOAD_LO 8'hCA
`define T2CS_ADDR_RELOAD_HI 8'hCB
`define T2CS_ADDR_COUNT_LO  8'hCC
`define T2CS_ADDR_COUNT_HI  8'hCD

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define T2CS_BIT_UPPER_OVF  7
`define T2CS_BIT_LOWER_OVF  6
`define T2CS_BIT_LOW_IRQ_EN 5
`define T2CS_BIT_CAP_EN     4
`define T2CS_BIT_SPLIT      3
`define T2CS_BIT_RUN        2
`define T2CS_BIT_UNUSED     1
`define T2CS_BIT_XCLK       0
`define T2CS_CTL_CFG_MASK   8'h3D
`define T2CS_CTL_RESET      8'h00
`define T2CS_BYTE_RESET     8'h00
`define T2CS_BIT_COUNT      8

// ---------------------------------------------------------------
// counter limits and count source dividers
// ---------------------------------------------------------------
`define T2CS_BYTE_MAX       8'hFF
`define T2CS_WORD_MAX       16'hFFFF
`define T2CS_SYS_DIV_LAST   4'hB
`define T2CS_EXT_DIV_LAST   3'h7

`endif

// ==== t2cs_pkg.sv ====
// shared types of the timer 2 control and status block
package t2cs_pkg;

	typedef logic [7:0] t2cs_byte_t;

	// count source of one byte counter
	typedef enum logic [1:0] {
		T2CS_SRC_SYS_DIV,
		T2CS_SRC_EXT_DIV,
		T2CS_SRC_SYS
	} t2cs_src_e;

endpackage

// ==== t2cs_tick_gen.sv ====
// count source enable pulses: system clock divided by 12 and external oscillator divided by 8
`timescale 1ns/100ps
`include "t2cs_regs.svh"

module t2cs_tick_gen
	import t2cs_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ext_osc_i,
	output logic      sys_div_tick_o,
	output logic      ext_div_tick_o
);

	logic [3:0] sys_cnt_q;
	logic       ext_s1_q;
	logic       ext_s2_q;
	logic       ext_s3_q;
	logic [2:0] ext_cnt_q;
	logic       ext_rise;

	// system clock prescaler, one pulse every twelve cycles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_cnt_q      <= 4'h0;
			sys_div_tick_o <= 1'b0;
		end else begin
			sys_div_tick_o <= (sys_cnt_q == `T2CS_SYS_DIV_LAST);
			sys_cnt_q      <= (sys_cnt_q == `T2CS_SYS_DIV_LAST) ? 4'h0 : sys_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_osc_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	assign ext_rise = ext_s2_q & ~ext_s3_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_cnt_q      <= 3'h0;
			ext_div_tick_o <= 1'b0;
		end else begin
			ext_div_tick_o <= ext_rise && (ext_cnt_q == `T2CS_EXT_DIV_LAST);
			if (ext_rise) begin
				ext_cnt_q <= ext_cnt_q + 3'h1; // wraps after eight edges
			end
		end
	end

endmodule // t2cs_tick_gen

// ==== t2cs_timer2.sv ====
// timer 2 control register, counter, reload pair, capture and interrupt request
`timescale 1ns/100ps
`include "t2cs_regs.svh"

// Overview of operation
// - upper overflow flag sets when the high byte rolls from 0xFF to 0x00.
// - in 16-bit mode the upper flag sets when the counter wraps 0xFFFF to 0x0000.
// - set upper flag with timer interrupt enabled requests an interrupt.
// - hardware never clears either overflow flag; only software writes clear them.
// - lower overflow flag sets on low byte rollover in both modes.
// - low byte irq enable plus timer interrupt enable lets low overflows interrupt.
// - with capture enabled, LOW_FREQ_OSCILLATOR falling edge copies counter into reload pair.
// - each capture event with timer interrupt enabled requests an interrupt.
// - split select 0 gives one 16-bit counter, 1 gives two 8-bit counters.
// - counting happens only while run control is 1, except the low byte in split mode.
// - in split mode run control gates the high byte only; low byte always runs.
// - control bit 1 reads zero and ignores writes.
// - external select 0 picks system clock /12, 1 picks external oscillator /8.
// - in split mode one external select serves both bytes; byte selects may override.
// - external /8 source is synchronised to the system clock before use.
// - control register at 0xC8, bit addressable, resets to all zeros.
// - 16-bit wrap loads the 16-bit reload pair into the counter.
// - in split mode each byte reloads its own reload byte on overflow.
// - byte clock select 1 chooses undivided system clock, 0 the external select source.
// - the interrupt request reaches the core only while the global timer enable is set.
module t2cs_timer2
	import t2cs_pkg::*;
(
	input  wire logic       MCLK_I,
	input  wire logic       SYS_RST_I,
	input  wire logic [7:0] SFR_ADDR_I,
	input  wire logic       SFR_WR_I,
	input  wire logic [7:0] SFR_WDATA_I,
	input  wire logic       SFR_RD_I,
	input  wire logic [7:0] SFR_BIT_ADDR_I,
	input  wire logic       SFR_BIT_WR_I,
	input  wire logic       SFR_BIT_WDATA_I,
	input  wire logic       SFR_BIT_RD_I,
	input  wire logic       UPPER_BYTE_CLOCK_SELECT_I,
	input  wire logic       LOWER_BYTE_CLOCK_SELECT_I,
	input  wire logic       TIMER_IRQ_ENABLE_I,
	input  wire logic       EXT_OSC_I,
	input  wire logic       LOW_FREQ_OSC_I,
	output logic [7:0]      SFR_RDATA_O,
	output logic            SFR_BIT_RDATA_O,
	output logic            TIMER_IRQ_O
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	t2cs_byte_t ctl_q, ctl_view;
	logic       upper_ovf_q, lower_ovf_q;
	t2cs_byte_t cnt_lo_q, cnt_lo_d;
	t2cs_byte_t cnt_hi_q, cnt_hi_d;
	t2cs_byte_t rl_lo_q, rl_lo_d;
	t2cs_byte_t rl_hi_q, rl_hi_d;
	t2cs_byte_t bit_wr_mask, bit_wr_val;
	logic       ctl_byte_wr;
	logic       set_upper, set_lower;
	logic       sys_div_tick, ext_div_tick;
	logic       tick_lo, tick_hi;
	logic       lfo_s1_q, lfo_s2_q, lfo_s3_q;
	logic       lfo_fall, capture;
	logic       split, run;
	t2cs_src_e  src_lo, src_hi;

	// ---------------------------------------------------------------
	// count sources
	// ---------------------------------------------------------------
	// synchronised source pulses
	t2cs_tick_gen u_tick_gen (
		.clk_i          (MCLK_I),
		.rst_i          (SYS_RST_I),
		.ext_osc_i      (EXT_OSC_I),
		.sys_div_tick_o (sys_div_tick),
		.ext_div_tick_o (ext_div_tick)
	);

	assign split = ctl_q[`T2CS_BIT_SPLIT];
	assign run   = ctl_q[`T2CS_BIT_RUN];

	always_comb begin
		if (LOWER_BYTE_CLOCK_SELECT_I) begin
			src_lo = T2CS_SRC_SYS;
		end else if (ctl_q[`T2CS_BIT_XCLK]) begin
			src_lo = T2CS_SRC_EXT_DIV;
		end else begin
			src_lo = T2CS_SRC_SYS_DIV;
		end
		if (UPPER_BYTE_CLOCK_SELECT_I) begin
			src_hi = T2CS_SRC_SYS;
		end else if (ctl_q[`T2CS_BIT_XCLK]) begin
			src_hi = T2CS_SRC_EXT_DIV;
		end else begin
			src_hi = T2CS_SRC_SYS_DIV;
		end
	end

	always_comb begin
		case (src_lo)
			T2CS_SRC_SYS:     tick_lo = 1'b1;
			T2CS_SRC_EXT_DIV: tick_lo = ext_div_tick;
			T2CS_SRC_SYS_DIV: tick_lo = sys_div_tick;
			default:          tick_lo = 1'b0;
		endcase
		case (src_hi)
			T2CS_SRC_SYS:     tick_hi = 1'b1;
			T2CS_SRC_EXT_DIV: tick_hi = ext_div_tick;
			T2CS_SRC_SYS_DIV: tick_hi = sys_div_tick;
			default:          tick_hi = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// low frequency oscillator edge
	// ---------------------------------------------------------------
	// two stages, then an edge stage
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			lfo_s1_q <= 1'b0;
			lfo_s2_q <= 1'b0;
			lfo_s3_q <= 1'b0;
		end else begin
			lfo_s1_q <= LOW_FREQ_OSC_I;
			lfo_s2_q <= lfo_s1_q;
			lfo_s3_q <= lfo_s2_q;
		end
	end

	assign lfo_fall = lfo_s3_q & ~lfo_s2_q;
	assign capture  = ctl_q[`T2CS_BIT_CAP_EN] & lfo_fall;

	// ---------------------------------------------------------------
	// write decode
	// ---------------------------------------------------------------
	assign ctl_byte_wr = SFR_WR_I && (SFR_ADDR_I == `T2CS_ADDR_CONTROL);

	// per bit byte or bit write
	for (genvar i = 0; i < `T2CS_BIT_COUNT; i++) begin : g_bit_wr
		logic bit_hit;
		assign bit_hit        = SFR_BIT_WR_I && (SFR_BIT_ADDR_I == 8'(`T2CS_ADDR_CONTROL + i));
		assign bit_wr_mask[i] = ctl_byte_wr | bit_hit;
		assign bit_wr_val[i]  = ctl_byte_wr ? SFR_WDATA_I[i] : SFR_BIT_WDATA_I;
	end

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	// configuration bits reset to zero
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			ctl_q <= `T2CS_CTL_RESET;
		end else begin
			ctl_q <= ((ctl_q & ~bit_wr_mask) | (bit_wr_val & bit_wr_mask)) & `T2CS_CTL_CFG_MASK;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			upper_ovf_q <= 1'b0;
			lower_ovf_q <= 1'b0;
		end else begin
			// a set in the clearing cycle wins
			upper_ovf_q <= (bit_wr_mask[`T2CS_BIT_UPPER_OVF] ? bit_wr_val[`T2CS_BIT_UPPER_OVF] : upper_ovf_q)
				| set_upper;
			lower_ovf_q <= (bit_wr_mask[`T2CS_BIT_LOWER_OVF] ? bit_wr_val[`T2CS_BIT_LOWER_OVF] : lower_ovf_q)
				| set_lower;
		end
	end

	// ---------------------------------------------------------------
	// counter next value
	// ---------------------------------------------------------------
	always_comb begin
		cnt_lo_d  = cnt_lo_q;
		cnt_hi_d  = cnt_hi_q;
		set_upper = 1'b0;
		set_lower = 1'b0;
		if (!split) begin
			if (run && tick_lo) begin
				if ({cnt_hi_q, cnt_lo_q} == `T2CS_WORD_MAX) begin
					{cnt_hi_d, cnt_lo_d} = {rl_hi_q, rl_lo_q};
					set_upper = 1'b1;
					set_lower = 1'b1;
				end else begin
					{cnt_hi_d, cnt_lo_d} = {cnt_hi_q, cnt_lo_q} + 16'h0001;
					set_lower = (cnt_lo_q == `T2CS_BYTE_MAX);
				end
			end
		end else begin
			if (tick_lo) begin
				if (cnt_lo_q == `T2CS_BYTE_MAX) begin
					cnt_lo_d  = rl_lo_q;
					set_lower = 1'b1;
				end else begin
					cnt_lo_d = cnt_lo_q + 8'h01;
				end
			end
			if (run && tick_hi) begin
				if (cnt_hi_q == `T2CS_BYTE_MAX) begin
					cnt_hi_d  = rl_hi_q;
					set_upper = 1'b1;
				end else begin
					cnt_hi_d = cnt_hi_q + 8'h01;
				end
			end
		end
		// capture also marks the upper flag
		if (capture) begin
			set_upper = 1'b1;
		end
		// software writes override counting
		if (SFR_WR_I && (SFR_ADDR_I == `T2CS_ADDR_COUNT_LO)) begin
			cnt_lo_d = SFR_WDATA_I;
		end
		if (SFR_WR_I && (SFR_ADDR_I == `T2CS_ADDR_COUNT_HI)) begin
			cnt_hi_d = SFR_WDATA_I;
		end
	end

	// counter bytes
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			cnt_lo_q <= `T2CS_BYTE_RESET;
			cnt_hi_q <= `T2CS_BYTE_RESET;
		end else begin
			cnt_lo_q <= cnt_lo_d;
			cnt_hi_q <= cnt_hi_d;
		end
	end

	// ---------------------------------------------------------------
	// reload pair
	// ---------------------------------------------------------------
	always_comb begin
		rl_lo_d = rl_lo_q;
		rl_hi_d = rl_hi_q;
		if (SFR_WR_I && (SFR_ADDR_I == `T2CS_ADDR_RELOAD_LO)) begin
			rl_lo_d = SFR_WDATA_I;
		end
		if (SFR_WR_I && (SFR_ADDR_I == `T2CS_ADDR_RELOAD_HI)) begin
			rl_hi_d = SFR_WDATA_I;
		end
		if (capture) begin
			rl_lo_d = cnt_lo_q;
			rl_hi_d = cnt_hi_q;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			rl_lo_q <= `T2CS_BYTE_RESET;
			rl_hi_q <= `T2CS_BYTE_RESET;
		end else begin
			rl_lo_q <= rl_lo_d;
			rl_hi_q <= rl_hi_d;
		end
	end

	// ---------------------------------------------------------------
	// read back
	// ---------------------------------------------------------------
	// bit 1 reads zero
	always_comb begin
		ctl_view                      = ctl_q;
		ctl_view[`T2CS_BIT_UPPER_OVF] = upper_ovf_q;
		ctl_view[`T2CS_BIT_LOWER_OVF] = lower_ovf_q;
		ctl_view[`T2CS_BIT_UNUSED]    = 1'b0;
	end

	// byte read, one cycle after the strobe
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			SFR_RDATA_O <= `T2CS_BYTE_RESET;
		end else if (SFR_RD_I) begin
			case (SFR_ADDR_I)
				`T2CS_ADDR_CONTROL:   SFR_RDATA_O <= ctl_view;
				`T2CS_ADDR_RELOAD_LO: SFR_RDATA_O <= rl_lo_q;
				`T2CS_ADDR_RELOAD_HI: SFR_RDATA_O <= rl_hi_q;
				`T2CS_ADDR_COUNT_LO:  SFR_RDATA_O <= cnt_lo_q;
				`T2CS_ADDR_COUNT_HI:  SFR_RDATA_O <= cnt_hi_q;
				default:              SFR_RDATA_O <= `T2CS_BYTE_RESET; // other addresses
			endcase
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			SFR_BIT_RDATA_O <= 1'b0;
		end else if (SFR_BIT_RD_I) begin
			if (SFR_BIT_ADDR_I[7:3] == 5'(`T2CS_ADDR_CONTROL >> 3)) begin
				SFR_BIT_RDATA_O <= ctl_view[SFR_BIT_ADDR_I[2:0]];
			end else begin
				SFR_BIT_RDATA_O <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// interrupt request
	// ---------------------------------------------------------------
	// upper flag requests; lower flag too with low byte irq enable
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			TIMER_IRQ_O <= 1'b0;
		end else begin
			TIMER_IRQ_O <= TIMER_IRQ_ENABLE_I
				& (upper_ovf_q | (ctl_q[`T2CS_BIT_LOW_IRQ_EN] & lower_ovf_q));
		end
	end

endmodule // t2cs_timer2

// ==== t2cs_timer2_checker.sv ====
// assertion checker bound to the timer 2 control and status block
`timescale 1ns/100ps

module t2cs_timer2_checker
	import t2cs_pkg::*;
(
	input  wire logic       MCLK_I,
	input  wire logic       SYS_RST_I,
	input  wire logic [7:0] SFR_ADDR_I,
	input  wire logic       SFR_WR_I,
	input  wire logic [7:0] SFR_WDATA_I,
	input  wire logic       SFR_RD_I,
	input  wire logic [7:0] SFR_BIT_ADDR_I,
	input  wire logic       SFR_BIT_WR_I,
	input  wire logic       SFR_BIT_RD_I,
	input  wire logic       TIMER_IRQ_ENABLE_I,
	input  wire logic [7:0] SFR_RDATA_O,
	input  wire logic       SFR_BIT_RDATA_O,
	input  wire logic       TIMER_IRQ_O
);
	// ------------------------
	// access decode
	// ------------------------
	wire logic rd_ctl = SFR_RD_I && SFR_ADDR_I == 8'hC8;
	wire logic wr_any = SFR_WR_I || SFR_BIT_WR_I;
	wire logic rd_bad = SFR_RD_I && !(SFR_ADDR_I inside {8'hC8, [8'hCA:8'hCD]});

	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	// ------------------------
	// port assertions
	// ------------------------
	AST_RESET_OUT:
		assert property (disable iff (1'b0) SYS_RST_I |=> SFR_RDATA_O == 8'h00 && !TIMER_IRQ_O)
		else $error("outputs not cleared in reset");
	AST_IRQ_GATE:
		assert property (!TIMER_IRQ_ENABLE_I |=> !TIMER_IRQ_O)
		else $error("interrupt request while disabled");
	AST_IRQ_SET:
		assert property (SFR_WR_I && SFR_ADDR_I == 8'hC8 && SFR_WDATA_I[7] && TIMER_IRQ_ENABLE_I
			##1 TIMER_IRQ_ENABLE_I |=> TIMER_IRQ_O)
		else $error("upper flag gave no interrupt request");
	AST_STICKY:
		assert property (TIMER_IRQ_O && TIMER_IRQ_ENABLE_I && !wr_any && !$past(wr_any) |=> TIMER_IRQ_O)
		else $error("flag dropped without software write");
	AST_BIT1_BYTE:
		assert property (rd_ctl |=> !SFR_RDATA_O[1])
		else $error("unused control bit read as one");
	AST_BIT1_BIT:
		assert property (SFR_BIT_RD_I && SFR_BIT_ADDR_I == 8'hC9 |=> !SFR_BIT_RDATA_O)
		else $error("unused bit address read as one");
	AST_UNMAPPED:
		assert property (rd_bad |=> SFR_RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	AST_CFG_BACK:
		assert property (SFR_WR_I && SFR_ADDR_I == 8'hC8 ##1 rd_ctl && !wr_any
			|=> (SFR_RDATA_O & 8'h3D) == ($past(SFR_WDATA_I, 2) & 8'h3D))
		else $error("control bits differ from write");
endmodule // t2cs_timer2_checker

bind t2cs_timer2 t2cs_timer2_checker u_chk (.MCLK_I, .SYS_RST_I, .SFR_ADDR_I, .SFR_WR_I, .SFR_WDATA_I,
	.SFR_RD_I, .SFR_BIT_ADDR_I, .SFR_BIT_WR_I, .SFR_BIT_RD_I, .TIMER_IRQ_ENABLE_I, .SFR_RDATA_O,
	.SFR_BIT_RDATA_O, .TIMER_IRQ_O);

// ==== tb_top.sv ====
// self-checking testbench of the timer 2 control and status block
`timescale 1ns/100ps

module tb_top;
	logic        clk, rst, wr, rd, bwr, bwd, brd, usel, lsel, ien, xosc, low_freq_oscillator, bq, irq;
	logic [7:0]  a, wd, ba, q;
	logic [15:0] v;
	int          failures, tests_run, k;

	t2cs_timer2 uut (
		.MCLK_I(clk), .SYS_RST_I(rst), .SFR_ADDR_I(a), .SFR_WR_I(wr), .SFR_WDATA_I(wd), .SFR_RD_I(rd),
		.SFR_BIT_ADDR_I(ba), .SFR_BIT_WR_I(bwr), .SFR_BIT_WDATA_I(bwd), .SFR_BIT_RD_I(brd),
		.UPPER_BYTE_CLOCK_SELECT_I(usel), .LOWER_BYTE_CLOCK_SELECT_I(lsel), .TIMER_IRQ_ENABLE_I(ien),
		.EXT_OSC_I(xosc), .LOW_FREQ_OSC_I(low_freq_oscillator), .SFR_RDATA_O(q), .SFR_BIT_RDATA_O(bq), .TIMER_IRQ_O(irq));

	// ------------------------
	// clocks and watchdog
	// ------------------------
	// system clock 25 MHz
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	// external oscillator, unrelated in phase
	initial begin
		xosc = 0;
		forever #48 xosc = ~xosc;
	end
	// cut a hang short
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		tally_and_finish();
	end

	// ------------------------
	// tasks and model
	// ------------------------
	task automatic chk(input string n, input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// one access on byte or bit bus, taken at the next edge
	task automatic acc(input logic b, w, input logic [7:0] ad, d);
		wr = w & !b;
		rd = !w & !b;
		bwr = w & b;
		brd = !w & b;
		a = ad;
		ba = ad;
		wd = d;
		bwd = d[0];
		@(posedge clk);
		#1;
	endtask
	// release strobes and let n edges pass
	task automatic rel(input int n);
		{wr, rd, bwr, brd} = 4'h0;
		repeat (n) @(posedge clk);
		#1;
	endtask
	// counter after n steps, split low byte after n+1: {upper flag, lower flag, count}
	function automatic logic [17:0] adv(input logic sp, run, input logic [15:0] c, r, input int n);
		logic uf;
		logic lf;
		{uf, lf} = 2'h0;
		for (int i = 0; i <= n; i++) begin
			if (!sp && run && i < n) begin
				lf |= c[7:0] == 8'hFF;
				uf |= c == 16'hFFFF;
				c = (c == 16'hFFFF) ? r : c + 16'h0001;
			end
			if (sp) begin
				lf |= c[7:0] == 8'hFF;
				c[7:0] = (c[7:0] == 8'hFF) ? r[7:0] : c[7:0] + 8'h01;
			end
			if (sp && run && i < n) begin
				uf |= c[15:8] == 8'hFF;
				c[15:8] = (c[15:8] == 8'hFF) ? r[15:8] : c[15:8] + 8'h01;
			end
		end
		return {uf, lf, c};
	endfunction
	// load, run idle+1 edges, stop run then split, compare
	task automatic cnt_case(input logic [7:0] ctl, input logic [15:0] c, r, input int idle, dv);
		logic [17:0] e;
		e = adv(ctl[3], ctl[2], c, r, (idle + 1) / dv);
		ien = 1'($urandom);
		acc(0, 1, 8'hCC, c[7:0]);
		acc(0, 1, 8'hCD, c[15:8]);
		acc(0, 1, 8'hCA, r[7:0]);
		acc(0, 1, 8'hCB, r[15:8]);
		acc(0, 1, 8'hC8, ctl);
		rel(idle);
		acc(1, 1, 8'hCA, 8'h00);
		acc(1, 1, 8'hCB, 8'h00);
		acc(0, 0, 8'hCC, 8'h00);
		chk("count low", q, e[7:0]);
		acc(0, 0, 8'hCD, 8'h00);
		chk("count high", q, e[15:8]);
		acc(0, 0, 8'hC8, 8'h00);
		chk("control", q, {e[17:16], ctl[5:4], 3'h0, ctl[0]});
		chk("irq", {7'h00, irq}, {7'h00, ien & (e[17] | ctl[5] & e[16])});
		acc(0, 1, 8'hC8, 8'h00);
		rel(1);
		chk("irq clear", {7'h00, irq}, 8'h00);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ------------------------
	// main sequence
	// ------------------------
	initial begin
		{rst, wr, rd, bwr, bwd, brd, ien, lsel} = 8'h80;
		{usel, low_freq_oscillator, a, wd, ba} = 26'h3000000;
		{failures, tests_run} = 64'h0;
		void'($urandom(32'hE3E6));
		repeat (3) @(posedge clk);
		#1;
		rst = 0;
		for (int i = 0; i < 7; i++) begin
			acc(0, 0, 8'hC8 + 8'(i), 8'h00);
			chk("reset read", q, 8'h00);
		end
		ien = 1;
		for (int i = 0; i < 9; i++) begin
			acc(1, 1, 8'hC8 + 8'(i), 8'h01);
			acc(1, 0, 8'hC8 + 8'(i), 8'h00);
			chk("bit read", {7'h00, bq}, {7'h00, i != 1 && i != 8});
		end
		acc(0, 0, 8'hC8, 8'h00);
		chk("bit writes", q, 8'hFD);
		for (int i = 0; i < 6; i++) begin
			v[7:0] = 8'($urandom);
			acc(0, 1, 8'hC8, v[7:0]);
			acc(0, 0, 8'hC8, 8'h00);
			chk("control write", q, v[7:0] & 8'hFD);
		end
		acc(0, 1, 8'hC8, 8'h00);
		lsel = 1;
		cnt_case(8'h04, 16'hFFFE, 16'h1234, 3, 1);
		cnt_case(8'h24, 16'h12FE, 16'h0000, 2, 1);
		cnt_case(8'h08, 16'hFEFE, 16'h5A3C, 4, 1);
		cnt_case(8'h2C, 16'hFEFD, 16'hA5C3, 5, 1);
		cnt_case(8'h01, 16'hFFFF, 16'h0000, 5, 1);
		for (int i = 0; i < 12; i++) begin
			cnt_case(8'($urandom) & 8'h2D, 16'($urandom_range(16'hFCFA, 16'hFFFF)), 16'($urandom), $urandom_range(1, 8), 1);
		end
		lsel = 0;
		cnt_case(8'h04, 16'h0000, 16'h0000, 119, 12);
		acc(0, 1, 8'hC8, 8'h05);
		rel(399);
		acc(1, 1, 8'hCA, 8'h00);
		acc(0, 0, 8'hCC, 8'h00);
		chk("ext count", 8'(q inside {[8'h1D:8'h20]}), 8'h01);
		lsel = 1;
		ien = 1;
		// split high byte on divided clock, low byte undivided
		usel = 0;
		acc(0, 1, 8'hCC, 8'h00);
		acc(0, 1, 8'hCD, 8'h00);
		acc(0, 1, 8'hC8, 8'h0C);
		rel(119);
		acc(1, 1, 8'hCA, 8'h00);
		acc(1, 1, 8'hCB, 8'h00);
		acc(0, 0, 8'hCC, 8'h00);
		v = 16'(adv(1'b1, 1'b0, 16'h0000, 16'h0000, 120));
		chk("split low undivided", q, v[7:0]);
		acc(0, 0, 8'hCD, 8'h00);
		v = 16'(adv(1'b0, 1'b1, 16'h0000, 16'h0000, 120 / 12));
		chk("split high divided", q, v[7:0]);
		usel = 1;
		acc(0, 1, 8'hCC, 8'h00);
		acc(0, 1, 8'hCD, 8'h00);
		acc(0, 1, 8'hC8, 8'h14);
		k = $urandom_range(4, 20);
		rel(k);
		low_freq_oscillator = 0;
		rel(8);
		acc(1, 1, 8'hCA, 8'h00);
		acc(0, 0, 8'hCA, 8'h00);
		v[7:0] = q;
		acc(0, 0, 8'hCB, 8'h00);
		v[15:8] = q;
		chk("capture", 8'(v >= 16'(k + 1) && v <= 16'(k + 3)), 8'h01);
		acc(0, 0, 8'hC8, 8'h00);
		chk("capture flag", q, 8'h90);
		chk("capture irq", {7'h00, irq}, 8'h01);
		rel(1);
		tally_and_finish();
	end
endmodule // tb_top
